// [atc_pkg.sv]
package atc_pkg;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] ATC_OFS_CFG    = 8'h00;
    localparam logic [7:0] ATC_OFS_CTRL   = 8'h04;
    localparam logic [7:0] ATC_OFS_CV1    = 8'h08;
    localparam logic [7:0] ATC_OFS_CV2    = 8'h0C;
    localparam logic [7:0] ATC_OFS_STATUS = 8'h10;
    localparam logic [7:0] ATC_OFS_RESULT = 8'h14;

    // ==========================================================
    // configuration, control and status field positions
    localparam int ATC_CFG_LSMP    = 0;
    localparam int ATC_CFG_LSTS    = 1;
    localparam int ATC_CFG_HSC     = 3;
    localparam int ATC_CFG_ICLK    = 4;
    localparam int ATC_CFG_ACKEN   = 6;
    localparam int ATC_CFG_AVERAGING_ENABLE    = 7;
    localparam int ATC_CFG_AVERAGING_COUNT_SELECT    = 8;
    localparam int ATC_CFG_MODE    = 10;
    localparam int ATC_CFG_DIV     = 12;
    localparam int ATC_CFG_CMPE    = 14;
    localparam int ATC_CFG_CMPGT   = 15;
    localparam int ATC_CFG_CMPRNG  = 16;
    localparam int ATC_CFG_W       = 17;
    localparam int ATC_CTRL_COMPLETE_INTERRUPT_ENABLE   = 0;
    localparam int ATC_CTRL_CONT   = 1;
    localparam int ATC_CTRL_START  = 2;
    localparam int ATC_STAT_CONVERSION_COMPLETE_FLAG   = 0;
    localparam int ATC_STAT_ACT    = 1;

    // ==========================================================
    // reset values and encodings
    localparam logic [16:0] ATC_CFG_RST    = 17'h00000;
    localparam logic [11:0] ATC_CV_RST     = 12'h000;
    localparam logic [11:0] ATC_RESULT_RST = 12'h000;
    localparam logic [1:0]  ATC_ICLK_ASYNC = 2'h3;
    localparam logic [1:0]  ATC_MODE_8B    = 2'h0;
    localparam logic [1:0]  ATC_MODE_10B   = 2'h1;

    // ==========================================================
    // timing counts
    localparam int          ATC_CLK_MHZ        = 200;
    localparam int          ATC_STARTUP_NS     = 5000;
    localparam int          ATC_STARTUP_CYCLES = (ATC_STARTUP_NS * ATC_CLK_MHZ + 999) / 1000;
    localparam logic [10:0] ATC_STARTUP_LAST   = 11'(ATC_STARTUP_CYCLES - 1);
    localparam logic [10:0] ATC_FIRST_BUS_LAST = 11'h004;
    localparam logic [5:0]  ATC_FIRST_LONG     = 6'h03;
    localparam logic [5:0]  ATC_FIRST_SHORT    = 6'h05;
    localparam logic [5:0]  ATC_BCT_8B         = 6'h11;
    localparam logic [5:0]  ATC_BCT_HI         = 6'h14;
    localparam logic [5:0]  ATC_LST_00         = 6'h14;
    localparam logic [5:0]  ATC_LST_01         = 6'h0C;
    localparam logic [5:0]  ATC_LST_10         = 6'h06;
    localparam logic [5:0]  ATC_LST_11         = 6'h02;
    localparam logic [5:0]  ATC_HSC_ADD        = 6'h02;
    localparam logic [2:0]  ATC_AVG_SHIFT_BASE = 3'h2;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FIRST_BUS,
        ST_STARTUP,
        ST_FIRST_CONVERTER_CLOCK,
        ST_CONVERT,
        ST_FINISH
    } atc_state_t;

endpackage : atc_pkg

// [atc_cmp_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface atc_cmp_if;
    logic [11:0] value;
    logic [11:0] cv1;
    logic [11:0] cv2;
    logic        greater;
    logic        range;
    logic        hit;

    modport req  (output value, output cv1, output cv2, output greater, output range, input hit);
    modport eval (input value, input cv1, input cv2, input greater, input range, output hit);
endinterface : atc_cmp_if
`default_nettype wire

// [atc_compare.sv]
`timescale 1ns/1ps
`default_nettype none
module atc_compare (
    atc_cmp_if.eval cmp    // value, thresholds and verdict
);
    logic lt1;
    logic gt2;
    logic inv;

    // ==========================================================
    // threshold evaluation
    always_comb begin
        lt1 = cmp.value < cmp.cv1;
        gt2 = cmp.value > cmp.cv2;
        inv = cmp.cv1 > cmp.cv2;
        unique case ({cmp.greater, cmp.range})
            2'b00: cmp.hit = lt1;
            2'b10: cmp.hit = !lt1;
            2'b01: cmp.hit = inv ? (lt1 && gt2) : (lt1 || gt2);
            2'b11: cmp.hit = inv ? (!lt1 || !gt2) : (!lt1 && !gt2);
        endcase
    end
endmodule : atc_compare
`default_nettype wire

// [atc_core.sv]
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module atc_core
    import atc_pkg::*;
(
    input  wire logic        clk_i,         // 200 MHz bus clock
    input  wire logic        rst_i,         // async reset, active high
    input  wire logic        psel,          // apb select
    input  wire logic        penable,       // apb access phase
    input  wire logic        pwrite,        // apb direction
    input  wire logic [7:0]  paddr,         // apb byte address
    input  wire logic [31:0] pwdata,        // apb write data
    output logic      [31:0] prdata,        // apb read data
    output logic             pready,        // apb ready
    output logic             pslverr,       // apb error, unmapped address
    input  wire logic [11:0] sample_i,      // converter output, right justified
    output logic             sample_take_o, // pulse: sample_i captured
    output logic             active_o,      // conversion sequence running
    output logic             irq_o,         // converter interrupt
    output logic             wake_o         // wakeup request to power control
);

    logic [16:0] cfg;
    logic        complete_interrupt_enable;
    logic        cont;
    logic [11:0] cv1;
    logic [11:0] cv2;
    logic [11:0] result;
    logic        conversion_complete_flag;
    logic        act;
    atc_state_t  state;
    logic [10:0] cnt;
    logic [4:0]  nsamp;
    logic [16:0] acc;
    logic [2:0]  div_cnt;
    logic        converter_clock_tick;

    logic        wr_en;
    logic        rd_en;
    logic        start;
    logic        result_read;
    logic        mapped;
    logic [31:0] next_prdata;

    logic [5:0]  first_converter_clock;
    logic [5:0]  base_conversion_cycles;
    logic [5:0]  lst;
    logic [5:0]  hsc;
    logic [5:0]  conv_cycles;
    logic [4:0]  factor_last;
    logic [2:0]  avg_shift;
    logic        need_startup;
    logic [11:0] res_mask;
    logic [11:0] avg;
    logic        pass;

    atc_cmp_if cmp ();

    atc_compare u_compare (
        .cmp (cmp)
    );

    // ==========================================================
    // apb slave: no wait states, data registered in setup
    assign wr_en       = psel && penable && pready && pwrite;
    assign rd_en       = psel && penable && pready && !pwrite;
    assign start       = wr_en && (paddr == ATC_OFS_CTRL) && pwdata[ATC_CTRL_START];
    assign result_read = rd_en && (paddr == ATC_OFS_RESULT);

    always_comb begin
        mapped      = 1'b1;
        next_prdata = 32'h00000000;
        unique case (paddr)
            ATC_OFS_CFG:    next_prdata = {15'h0000, cfg};
            ATC_OFS_CTRL:   next_prdata = {30'h0, cont, complete_interrupt_enable};
            ATC_OFS_CV1:    next_prdata = {20'h00000, cv1};
            ATC_OFS_CV2:    next_prdata = {20'h00000, cv2};
            ATC_OFS_STATUS: next_prdata = {30'h0, act, conversion_complete_flag};
            ATC_OFS_RESULT: next_prdata = {20'h00000, result};
            default:        mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (psel && !penable) begin
                prdata <= pwrite ? 32'h00000000 : next_prdata;
            end
        end
    end

    // ==========================================================
    // software-written registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg  <= ATC_CFG_RST;
            complete_interrupt_enable <= 1'b0;
            cont <= 1'b0;
            cv1  <= ATC_CV_RST;
            cv2  <= ATC_CV_RST;
        end else if (wr_en) begin
            unique case (paddr)
                ATC_OFS_CFG: cfg <= pwdata[ATC_CFG_W-1:0];
                ATC_OFS_CTRL: begin
                    complete_interrupt_enable <= pwdata[ATC_CTRL_COMPLETE_INTERRUPT_ENABLE];
                    cont <= pwdata[ATC_CTRL_CONT];
                end
                ATC_OFS_CV1: cv1 <= pwdata[11:0];
                ATC_OFS_CV2: cv2 <= pwdata[11:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // converter clock enable from bus clock divider (1, 2, 4, 8)
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_cnt   <= 3'h0;
            converter_clock_tick <= 1'b0;
        end else begin
            converter_clock_tick <= (div_cnt == 3'((4'h1 << cfg[ATC_CFG_DIV +: 2]) - 4'h1));
            if (div_cnt == 3'((4'h1 << cfg[ATC_CFG_DIV +: 2]) - 4'h1)) begin
                div_cnt <= 3'h0;
            end else begin
                div_cnt <= div_cnt + 3'h1;
            end
        end
    end

    // ==========================================================
    // conversion timing terms
    always_comb begin
        first_converter_clock = cfg[ATC_CFG_LSMP] ? ATC_FIRST_LONG : ATC_FIRST_SHORT;
        need_startup = (cfg[ATC_CFG_ICLK +: 2] == ATC_ICLK_ASYNC)
                       && !cfg[ATC_CFG_ACKEN];
        base_conversion_cycles = (cfg[ATC_CFG_MODE +: 2] == ATC_MODE_8B) ? ATC_BCT_8B : ATC_BCT_HI;
        lst = 6'h00;
        if (cfg[ATC_CFG_LSMP]) begin
            unique case (cfg[ATC_CFG_LSTS +: 2])
                2'h0: lst = ATC_LST_00;
                2'h1: lst = ATC_LST_01;
                2'h2: lst = ATC_LST_10;
                2'h3: lst = ATC_LST_11;
            endcase
        end
        hsc = cfg[ATC_CFG_HSC] ? ATC_HSC_ADD : 6'h00;
        conv_cycles = base_conversion_cycles + lst + hsc;
        avg_shift   = cfg[ATC_CFG_AVERAGING_ENABLE] ? ATC_AVG_SHIFT_BASE + {1'b0, cfg[ATC_CFG_AVERAGING_COUNT_SELECT +: 2]} : 3'h0;
        factor_last = 5'((6'h01 << avg_shift) - 6'h01);
        unique case (cfg[ATC_CFG_MODE +: 2])
            ATC_MODE_8B:  res_mask = 12'h0FF;
            ATC_MODE_10B: res_mask = 12'h3FF;
            default:      res_mask = 12'hFFF;
        endcase
    end

    // average formed by shifting the power-of-two sum
    assign avg = 12'(acc >> avg_shift);

    // compare sees only the averaged value
    assign cmp.value   = avg;
    assign cmp.cv1     = cv1;
    assign cmp.cv2     = cv2;
    assign cmp.greater = cfg[ATC_CFG_CMPGT];
    assign cmp.range   = cfg[ATC_CFG_CMPRNG];
    assign pass        = !cfg[ATC_CFG_CMPE] || cmp.hit;

    // ==========================================================
    // sequencer; a start write while busy restarts from the first adder
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state         <= ST_IDLE;
            cnt           <= 11'h000;
            nsamp         <= 5'h00;
            acc           <= 17'h00000;
            act           <= 1'b0;
            sample_take_o <= 1'b0;
        end else begin
            sample_take_o <= 1'b0;
            if (start) begin
                state <= ST_FIRST_BUS;
                cnt   <= 11'h000;
                nsamp <= 5'h00;
                acc   <= 17'h00000;
                act   <= 1'b1;
            end else begin
                unique case (state)
                    ST_IDLE: act <= 1'b0;
                    ST_FIRST_BUS: begin
                        cnt <= cnt + 11'h001;
                        if (cnt == ATC_FIRST_BUS_LAST) begin
                            cnt   <= 11'h000;
                            state <= need_startup ? ST_STARTUP : ST_FIRST_CONVERTER_CLOCK;
                        end
                    end
                    ST_STARTUP: begin
                        cnt <= cnt + 11'h001;
                        if (cnt == ATC_STARTUP_LAST) begin
                            cnt   <= 11'h000;
                            state <= ST_FIRST_CONVERTER_CLOCK;
                        end
                    end
                    ST_FIRST_CONVERTER_CLOCK: begin
                        if (converter_clock_tick) begin
                            cnt <= cnt + 11'h001;
                            if (cnt == 11'(first_converter_clock - 6'h01)) begin
                                cnt   <= 11'h000;
                                state <= ST_CONVERT;
                            end
                        end
                    end
                    ST_CONVERT: begin
                        if (converter_clock_tick) begin
                            cnt <= cnt + 11'h001;
                            if (cnt == 11'(conv_cycles - 6'h01)) begin
                                // sample only accumulated, no flag per sample
                                cnt           <= 11'h000;
                                acc           <= acc + {5'h00, sample_i & res_mask};
                                sample_take_o <= 1'b1;
                                nsamp         <= nsamp + 5'h01;
                                if (nsamp == factor_last) begin
                                    state <= ST_FINISH;
                                end
                            end
                        end
                    end
                    ST_FINISH: begin
                        // continuous runs skip the first adder
                        nsamp <= 5'h00;
                        acc   <= 17'h00000;
                        state <= cont ? ST_CONVERT : ST_IDLE;
                        act   <= cont;
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    assign active_o = act;

    // ==========================================================
    // result transfer and completion flag; setting beats a clearing read
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            result <= ATC_RESULT_RST;
            conversion_complete_flag   <= 1'b0;
        end else begin
            if (state == ST_FINISH && !start && pass) begin
                result <= avg;
                conversion_complete_flag   <= 1'b1;
            end else if (result_read) begin
                conversion_complete_flag <= 1'b0;
            end
            // failing compare leaves result and flag alone
        end
    end

    // ==========================================================
    // interrupt and wake: no clock gating here, so wait/stop keep running
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o  <= 1'b0;
            wake_o <= 1'b0;
        end else begin
            irq_o  <= conversion_complete_flag && complete_interrupt_enable;
            wake_o <= conversion_complete_flag && complete_interrupt_enable;
        end
    end

endmodule : atc_core
`default_nettype wire

// [atc_core_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module atc_core_chk
    import atc_pkg::*;
(
    input wire logic        clk_i,         // bus clock
    input wire logic        rst_i,         // async reset
    input wire logic        psel,          // apb select
    input wire logic        penable,       // apb access
    input wire logic        pwrite,        // apb direction
    input wire logic [7:0]  paddr,         // apb address
    input wire logic [31:0] pwdata,        // apb write data
    input wire logic [31:0] prdata,        // apb read data
    input wire logic        pready,        // apb ready
    input wire logic        pslverr,       // apb error
    input wire logic [11:0] sample_i,      // converter code
    input wire logic        sample_take_o, // sample pulse
    input wire logic        active_o,      // sequence running
    input wire logic        irq_o,         // interrupt
    input wire logic        wake_o         // wakeup
);
    // ============
    // shadow of software settings
    logic [16:0] cfg;
    logic        ie_q;
    logic        first;
    logic [11:0] cnt;
    logic [5:0]  takes;
    logic [5:0]  conv;
    logic [5:0]  factor;
    logic [11:0] lo;
    logic [3:0]  dv;
    logic        wr;
    logic        start;

    assign wr     = psel && penable && pready && pwrite;
    assign start  = wr && paddr == ATC_OFS_CTRL && pwdata[ATC_CTRL_START];
    assign conv   = (cfg[11:10] == 2'h0 ? 6'h11 : 6'h14) + (cfg[3] ? 6'h02 : 6'h00)
                  + (!cfg[0] ? 6'h00 : cfg[2:1] == 2'h0 ? 6'h14 : cfg[2:1] == 2'h1 ? 6'h0C
                  : cfg[2:1] == 2'h2 ? 6'h06 : 6'h02);
    assign factor = cfg[7] ? 6'h04 << cfg[9:8] : 6'h01;
    assign dv     = 4'h1 << cfg[13:12];
    // divider phase at start is why the first sample gets a small window
    assign lo     = 12'h005 + (cfg[5:4] == 2'h3 && !cfg[6] ? 12'h3E8 : 12'h000)
                  + ((cfg[0] ? 12'h003 : 12'h005) + 12'(conv)) * 12'(dv);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg  <= 17'h00000;
            ie_q <= 1'h0;
        end else begin
            if (wr && paddr == ATC_OFS_CFG) cfg <= pwdata[16:0];
            if (wr && paddr == ATC_OFS_CTRL) ie_q <= pwdata[ATC_CTRL_COMPLETE_INTERRUPT_ENABLE];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt   <= 12'h000;
            first <= 1'h0;
            takes <= 6'h00;
        end else if (start) begin
            cnt   <= 12'h001;
            first <= 1'h1;
            takes <= 6'h00;
        end else if (sample_take_o) begin
            cnt   <= 12'h001;
            first <= 1'h0;
            takes <= takes + 6'h01;
        end else if (cnt != 12'hFFF) begin
            cnt <= cnt + 12'h001;
        end
    end

    // ============
    // properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence apb_setup_s;
        psel && !penable;
    endsequence
    sequence apb_done_s;
        psel && penable && pready;
    endsequence
    sequence first_take_s;
        sample_take_o && first;
    endsequence

    apb_ready_a: assert property (apb_setup_s |=> apb_done_s) else $error("no ready after setup");
    unmapped_err_a: assert property (psel && penable && pready && paddr > 8'h14 |-> pslverr)
        else $error("unmapped access without error");
    first_time_a:
        assert property (first_take_s |-> cnt >= lo + 12'h002 - 12'(dv) && cnt <= lo + 12'h003)
        else $error("first sample mistimed");
    conv_gap_a:
        assert property (sample_take_o && !first |-> cnt == 12'(conv) * 12'(dv))
        else $error("conversion time wrong");
    take_active_a: assert property (sample_take_o |-> active_o) else $error("sample while idle");
    avg_count_a:
        assert property ($fell(active_o) |-> takes == factor) else $error("sample count wrong");
    irq_cause_a:
        assert property ($rose(irq_o) |-> ie_q && takes == factor) else $error("interrupt without cause");
    wake_follow_a: assert property (wake_o == irq_o) else $error("wake differs from irq");
endmodule : atc_core_chk

bind atc_core atc_core_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_i(sample_i), .sample_take_o(sample_take_o), .active_o(active_o),
    .irq_o(irq_o), .wake_o(wake_o));
`default_nettype wire

// [atc_sample_src.sv]
`timescale 1ns/1ps
`default_nettype none
module atc_sample_src (
    input  wire logic        clk_i,    // bus clock
    input  wire logic        rst_i,    // async reset
    input  wire logic        take_i,   // sample captured
    input  wire logic        active_i, // sequence running
    input  wire logic [11:0] lvl_a_i,  // even samples
    input  wire logic [11:0] lvl_b_i,  // odd samples
    output logic      [11:0] sample_o  // converter code
);
    logic odd;

    // ============
    // alternate levels so a stuck accumulator shows
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            odd <= 1'h0;
        end else if (!active_i) begin
            odd <= 1'h0;
        end else if (take_i) begin
            odd <= ~odd;
        end
    end

    assign sample_o = odd ? lvl_b_i : lvl_a_i;
endmodule : atc_sample_src
`default_nettype wire

// [adc_timing_average_compare_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_timing_average_compare_bench
    import atc_pkg::*;
;
    logic        clk_i;
    logic        rst_i;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [11:0] sample;
    logic        take;
    logic        active_o;
    logic        irq_o;
    logic        wake_o;
    logic [11:0] lvl_a;
    logic [11:0] lvl_b;
    logic [11:0] last;
    logic [32:0] exp_q[$];
    int          err_count;
    int          check_count;

    localparam logic [16:0] TCFG [12] = '{17'h00000, 17'h00401, 17'h0080B, 17'h03005, 17'h0000F, 17'h00008,
        17'h00030, 17'h00071, 17'h00880, 17'h00980, 17'h00A80, 17'h00B80};
    // cfg, first value, second value, even level, odd level, pass
    localparam logic [65:0] TCMP [14] = '{
        {17'h04800, 12'h0C8, 12'h000, 12'h0C7, 12'h0C7, 1'h1}, {17'h04800, 12'h0C8, 12'h000, 12'h0C8, 12'h0C8, 1'h0},
        {17'h0C800, 12'h0C8, 12'h000, 12'h0C8, 12'h0C8, 1'h1}, {17'h0C800, 12'h0C8, 12'h000, 12'h0C7, 12'h0C7, 1'h0},
        {17'h14800, 12'h064, 12'h12C, 12'h12D, 12'h12D, 1'h1}, {17'h14800, 12'h064, 12'h12C, 12'h12C, 12'h12C, 1'h0},
        {17'h14800, 12'h12C, 12'h064, 12'h0C8, 12'h0C8, 1'h1}, {17'h14800, 12'h12C, 12'h064, 12'h064, 12'h064, 1'h0},
        {17'h1C800, 12'h064, 12'h12C, 12'h12C, 12'h12C, 1'h1}, {17'h1C800, 12'h064, 12'h12C, 12'h12D, 12'h12D, 1'h0},
        {17'h1C800, 12'h12C, 12'h064, 12'h064, 12'h064, 1'h1}, {17'h1C800, 12'h12C, 12'h064, 12'h0C8, 12'h0C8, 1'h0},
        {17'h04880, 12'h096, 12'h000, 12'h064, 12'h12C, 1'h0}, {17'h0C880, 12'h0C8, 12'h000, 12'h064, 12'h12C, 1'h1}};

    atc_core uut (.clk_i(clk_i), .rst_i(rst_i), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_i(sample), .sample_take_o(take), .active_o(active_o), .irq_o(irq_o), .wake_o(wake_o));
    atc_sample_src u_src (.clk_i(clk_i), .rst_i(rst_i), .take_i(take), .active_i(active_o),
        .lvl_a_i(lvl_a), .lvl_b_i(lvl_b), .sample_o(sample));

    initial begin
        clk_i = 1'h0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // ============
    // bounded waits; a hang ends the run
    task automatic wait_on(input logic rdy, input logic lvl, input int lim);
        int n;
        for (n = 0; n < lim; n++) begin
            @(posedge clk_i);
            if ((rdy ? pready : active_o) === lvl) break;
        end
        if (n == lim) begin
            check(33'(~lvl), 33'(lvl));
            stop_test();
        end
    endtask : wait_on

    task automatic apb(input logic w, input logic [7:0] a, input logic [32:0] d);
        if (!w) exp_q.push_back(d);
        psel    <= 1'h1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d[31:0];
        @(posedge clk_i);
        penable <= 1'h1;
        wait_on(1'h1, 1'h1, 20);
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge clk_i);
    endtask : apb

    always @(posedge clk_i) begin
        if (psel && penable && pready === 1'h1 && !pwrite) begin
            if (exp_q.size() > 0) check({pslverr, prdata}, exp_q.pop_front());
            else check(33'h0, 33'h1);
        end
    end

    task automatic run(input logic [16:0] c, input logic [11:0] cv1, input logic [11:0] cv2,
                       input logic [11:0] a, input logic [11:0] b, input logic ok, input logic ie);
        logic [11:0] v;
        v = c[7] ? 12'((13'(a) + 13'(b)) >> 1) : a;
        lvl_a <= a;
        lvl_b <= b;
        apb(1'h1, ATC_OFS_CV1, {21'h0, cv1});
        apb(1'h1, ATC_OFS_CV2, {21'h0, cv2});
        apb(1'h1, ATC_OFS_CFG, {16'h0, c});
        if (c[6]) repeat (1000) @(posedge clk_i);
        apb(1'h1, ATC_OFS_CTRL, 33'h4 | 33'(ie));
        wait_on(1'h0, 1'h1, 10);
        wait_on(1'h0, 1'h0, 4000);
        repeat (3) @(posedge clk_i);
        check({32'h0, irq_o}, {32'h0, ok & ie});
        check({31'h0, wake_o, irq_o}, {31'h0, ok & ie, ok & ie});
        if (ok) last = v;
        apb(1'h0, ATC_OFS_STATUS, {32'h0, ok});
        apb(1'h0, ATC_OFS_RESULT, {21'h0, last});
        apb(1'h0, ATC_OFS_STATUS, 33'h0);
        $display("test cfg %h done", c);
    endtask : run

    initial begin
        int          i;
        logic [11:0] m;
        logic [65:0] e;
        rst_i   = 1'h1;
        psel    = 1'h0;
        penable = 1'h0;
        pwrite  = 1'h0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        lvl_a   = 12'h000;
        lvl_b   = 12'h000;
        last    = 12'h000;
        void'($urandom(32'h13601083));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        apb(1'h0, ATC_OFS_CFG, 33'h0);
        apb(1'h0, ATC_OFS_RESULT, 33'h0);
        apb(1'h0, 8'h18, 33'h100000000);
        apb(1'h1, 8'h18, 33'hFFFFFFFF);
        apb(1'h0, ATC_OFS_CFG, 33'h0);
        $display("test reset done");
        for (i = 0; i < 12; i++) begin
            m = TCFG[i][11:10] == 2'h0 ? 12'h0FF : TCFG[i][11:10] == 2'h1 ? 12'h3FF : 12'hFFF;
            run(TCFG[i], 12'($urandom), 12'($urandom), 12'($urandom) & m, 12'($urandom) & m, 1'h1,
                i[1:0] != 2'h3);
        end
        for (i = 0; i < 14; i++) begin
            e = TCMP[i];
            run(e[65:49], e[48:37], e[36:25], e[24:13], e[12:1], e[0], i[1:0] != 2'h2);
        end
        stop_test();
    end
endmodule : adc_timing_average_compare_bench
`default_nettype wire
